// File: bench/divp_cpu_model.sv
// Purpose: core fetch model that takes offered vectors
// Assumes: ack_delay from the bench, 0 answers at once
// Notes:   acks only while a vector is offered, never twice for one
`timescale 1ns/100ps
module divp_cpu_model (
    // clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // vector side
    input wire logic        vector_req,
    input wire logic [41:0] offer,
    input wire logic [3:0]  ack_delay,
    output logic            vector_ack,
    // fetched vector, one-cycle pulse
    output logic            taken,
    output logic [41:0]     taken_vec
);
    logic [3:0] wait_q;
    always_ff @(posedge clk) begin
        vector_ack <= 1'b0;
        taken <= 1'b0;
        if (!resetn) begin
            wait_q <= 4'h0;
        end else if (vector_req && !vector_ack) begin
            if (wait_q >= ack_delay) begin
                // capture with the ack: fields are promised only while offered
                vector_ack <= 1'b1;
                taken <= 1'b1;
                taken_vec <= offer;
                wait_q <= 4'h0;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule // divp_cpu_model

// File: bench/divp_vc_props.sv
// Purpose: port-level temporal checks for the vector block
// Assumes: page pointers stay put while a vector is offered
// Notes:   bound into every instance of the vector block
`timescale 1ns/100ps
module divp_vc_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // inputs seen
    input wire logic        timer_aggregate_irq,
    input wire logic        card0_irq,
    input wire logic [1:0]  serial_port_zero_select,
    input wire logic [23:0] vector_base_low_page,
    input wire logic [23:0] vector_base_high_page,
    input wire logic        flag_clear_wr,
    input wire logic [31:0] flag_clear_data,
    input wire logic        soft_reset,
    input wire logic        vector_ack,
    // outputs
    input wire logic        vector_req,
    input wire logic [31:0] vector_addr_q,
    input wire logic [4:0]  vector_num_q,
    input wire logic [4:0]  vector_prio_q,
    input wire logic [31:0] irq_pending_flags
);
    // own copy of the priority ladder so a slip in the design table shows up
    localparam int P [32] = '{0, 1, 3, 5, 6, 7, 9, 10, 11, 13, 14, 15, 26, 26, 21, 22,
                              4, 8, 12, 16, 19, 20, 23, 24, 2, 25, 26, 14, 15, 16, 17, 18};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_retire;
        vector_req && vector_ack;
    endsequence
    property p_hold;
        vector_req && !vector_ack |=> vector_req && $stable(vector_addr_q)
            && $stable(vector_num_q) && $stable(vector_prio_q);
    endproperty
    a_hold: assert property (p_hold) else $error("offered vector moved");
    property p_gap;
        s_retire |=> !vector_req;
    endproperty
    a_gap: assert property (p_gap) else $error("no idle cycle after ack");
    property p_offset;
        vector_req |-> vector_addr_q[7:0] == {vector_num_q, 3'h0};
    endproperty
    a_offset: assert property (p_offset) else $error("bad offset");
    property p_page;
        vector_req |-> vector_addr_q[31:8] == (vector_num_q[4:3] == 2'h2 ?
            vector_base_high_page : vector_base_low_page);
    endproperty
    a_page: assert property (p_page) else $error("bad page");
    property p_prio;
        vector_req |-> vector_prio_q == 5'(P[vector_num_q]);
    endproperty
    a_prio: assert property (p_prio)
        else $error("bad priority");
    property p_nmi;
        !irq_pending_flags[1];
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi flag set");
    property p_soft;
        soft_reset |=> irq_pending_flags[0];
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset lost");
    property p_clear;
        flag_clear_wr && flag_clear_data[4] && !$rose(timer_aggregate_irq)
            |=> !irq_pending_flags[4];
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");
    property p_keep;
        flag_clear_wr && flag_clear_data[4] && $rose(timer_aggregate_irq)
            |=> irq_pending_flags[4];
    endproperty
    a_keep: assert property (p_keep) else $error("event lost to clear");
    property p_card;
        serial_port_zero_select == 2'h0 && $rose(card0_irq) |=> irq_pending_flags[5];
    endproperty
    a_card: assert property (p_card) else $error("card source lost");
endmodule // divp_vc_props
bind divp_vector_ctrl divp_vc_props u_props (.clk(clk), .resetn(resetn),
    .timer_aggregate_irq(timer_aggregate_irq), .card0_irq(card0_irq),
    .serial_port_zero_select(serial_port_zero_select), .vector_base_low_page(vector_base_low_page),
    .vector_base_high_page(vector_base_high_page), .flag_clear_wr(flag_clear_wr),
    .flag_clear_data(flag_clear_data), .soft_reset(soft_reset), .vector_ack(vector_ack),
    .vector_req(vector_req), .vector_addr_q(vector_addr_q), .vector_num_q(vector_num_q),
    .vector_prio_q(vector_prio_q), .irq_pending_flags(irq_pending_flags));

// File: bench/tb_top.sv
// Purpose: self-checking bench for the vector and priority block
// Assumes: page pointers fixed for the whole run
// Notes:   expected order comes from the bench's own priority ladder
`timescale 1ns/100ps
module tb_top;
    logic clk, resetn, clr_wr, soft_reset, trap_req, vector_ack, vector_req, taken;
    logic [23:0] src, low, high, r;
    logic [2:0] pin;
    logic [1:0] sel0, sel1;
    logic [4:0] trap_num, vnum, vprio;
    logic [3:0] ack_delay;
    logic [31:0] mask, clr_data, vaddr, flags, exp;
    logic [41:0] taken_vec;
    int fail_count, num_checks;
    localparam int PE [32] = '{0, 1, 3, 5, 6, 7, 9, 10, 11, 13, 14, 15, 26, 26, 21, 22,
                               4, 8, 12, 16, 19, 20, 23, 24, 2, 25, 26, 14, 15, 16, 17, 18};
    localparam int NUMS [24] = '{4, 6, 8, 5, 7, 5, 7, 9, 11, 9, 11, 14, 15, 16, 17, 18, 19, 20, 21,
                                 22, 23, 24, 25, 26};
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    divp_vector_ctrl dut (.clk(clk), .resetn(resetn), .ext_user_irq_zero_pin(pin[0]),
        .ext_user_irq_one_pin(pin[1]), .wakeup_pin(pin[2]), .timer_aggregate_irq(src[0]),
        .uart_irq(src[1]), .dma_aggregate_irq(src[2]), .audio0_tx_irq(src[3]),
        .audio0_rx_irq(src[4]), .card0_irq(src[5]), .card0_sdio_irq(src[6]),
        .audio1_tx_irq(src[7]), .audio1_rx_irq(src[8]), .card1_irq(src[9]),
        .card1_sdio_irq(src[10]), .audio2_tx_irq(src[11]), .audio2_rx_irq(src[12]),
        .audio3_tx_irq(src[13]), .audio3_rx_irq(src[14]), .rtc_irq(src[15]), .spi_irq(src[16]),
        .usb_irq(src[17]), .gpio_aggregate_irq(src[18]), .emif_error_irq(src[19]),
        .i2c_irq(src[20]), .bus_fault_irq(src[21]), .data_logging_irq(src[22]),
        .os_kernel_irq(src[23]), .serial_port_zero_select(sel0), .serial_port_one_select(sel1),
        .irq_enable_mask(mask), .vector_base_low_page(low), .vector_base_high_page(high),
        .flag_clear_wr(clr_wr), .flag_clear_data(clr_data), .soft_reset(soft_reset),
        .trap_req(trap_req), .trap_num(trap_num), .vector_ack(vector_ack), .vector_req(vector_req),
        .vector_addr_q(vaddr), .vector_num_q(vnum), .vector_prio_q(vprio),
        .irq_pending_flags(flags));
    divp_cpu_model u_cpu (.clk(clk), .resetn(resetn), .vector_req(vector_req),
        .offer({vaddr, vnum, vprio}), .ack_delay(ack_delay), .vector_ack(vector_ack),
        .taken(taken), .taken_vec(taken_vec));
    function automatic int best(input logic [31:0] s);
        best = 32;
        for (int n = 0; n < 32; n++) begin
            if (s[n] && (best == 32 || PE[n] < PE[best])) best = n;
        end
    endfunction
    // muxed sources only count when their port mode selects them
    function automatic bit live(input int i);
        case (i)
            3, 4: live = sel0 == 2'h1;
            5, 6: live = sel0 == 2'h0;
            7, 8: live = sel1 == 2'h1;
            9, 10: live = sel1 == 2'h0;
            default: live = 1'b1;
        endcase
    endfunction
    task automatic check(input string what, input logic [41:0] e, input logic [41:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    // expected fetch: page by number group, 8-byte slots, own priority ladder
    function automatic logic [41:0] vec_of(input int n);
        logic [23:0] page;
        page = (n / 8 == 2) ? high : low;
        vec_of = {{page, 8'h00} + 32'(n * 8), 5'(n), 5'(PE[n])};
    endfunction
    task automatic get_vec(input int n);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (taken !== 1'b1 && k < 300);
        check("taken", 42'h1, {41'h0, taken});
        check("vector", vec_of(n), taken_vec);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(9864));
        {src, pin, clr_wr, soft_reset, trap_req, trap_num, clr_data, sel0, sel1, ack_delay} = '0;
        {resetn, mask, low, high} = {1'b0, 32'hFFFF_FFFF, 24'($urandom), 24'($urandom)};
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        get_vec(0);
        for (int i = 0; i < 27; i++) begin
            {sel0, sel1, ack_delay} <= 8'($urandom);
            @(posedge clk);
            if (i < 24) src[i] <= 1'b1;
            else pin[i - 24] <= 1'b1;
            @(posedge clk);
            {src, pin} <= '0;
            if (i > 23) get_vec(i == 26 ? 18 : i - 22);
            else if (live(i)) get_vec(NUMS[i]);
            else begin
                repeat (6) @(posedge clk);
                check("idle", 42'h0, {vector_req, flags});
            end
        end
        for (int n = 0; n < 32; n++) begin
            {trap_req, trap_num} <= {1'b1, 5'(n)};
            @(posedge clk);
            trap_req <= 1'b0;
            get_vec(n);
        end
        repeat (20) begin
            {sel0, sel1, ack_delay} <= 8'($urandom);
            r = 24'($urandom);
            @(posedge clk);
            src <= r;
            exp = '0;
            for (int i = 0; i < 24; i++) begin
                if (r[i] && live(i)) exp[NUMS[i]] = 1'b1;
            end
            @(posedge clk);
            src <= '0;
            while (exp != 0) begin
                get_vec(best(exp));
                exp[best(exp)] = 1'b0;
            end
        end
        {mask, src[0]} <= {32'hFFFF_FFEF, 1'b1};
        @(posedge clk);
        src <= '0;
        repeat (4) @(posedge clk);
        check("masked", 42'h10, {vector_req, flags});
        // an event in the clearing cycle must survive the clear
        {clr_wr, clr_data, src[0]} <= {1'b1, 32'h10, 1'b1};
        @(posedge clk);
        {clr_wr, src} <= '0;
        repeat (2) @(posedge clk);
        check("set wins", 42'h10, {vector_req, flags});
        {clr_wr, clr_data} <= {1'b1, 32'h10};
        @(posedge clk);
        {clr_wr, mask} <= {1'b0, 32'hFFFF_FFFF};
        repeat (2) @(posedge clk);
        check("cleared", 42'h0, {vector_req, flags});
        resetn <= 1'b0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        get_vec(0);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        get_vec(0);
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end
endmodule // tb_top

// File: verilog/divp_pkg.sv
// Purpose: shared constants for the interrupt vector and priority block
// Assumes: 32 interrupt numbers, 8-byte vector slots, 24-bit vector page pointers
// Notes:   lower priority number means more urgent
package divp_pkg;

    localparam int unsigned NUM_IRQ    = 32;
    localparam int unsigned NUM_W      = 5;
    localparam int unsigned PRIO_W     = 5;
    localparam int unsigned PAGE_W     = 24;
    localparam int unsigned ADDR_W     = 32;
    localparam int unsigned OFFSET_W   = 8;
    localparam int unsigned SLOT_SHIFT = 3;

    // interrupt numbers with fixed roles
    localparam logic [4:0] NUM_RESET    = 5'h00;
    localparam logic [4:0] NUM_NMI      = 5'h01;
    localparam logic [4:0] NUM_EXT0     = 5'h02;
    localparam logic [4:0] NUM_EXT1     = 5'h03;
    localparam logic [4:0] NUM_PROGRAMMABLE_TX_IRQ_ZERO    = 5'h05;
    localparam logic [4:0] NUM_PROGRAMMABLE_RX_IRQ_ONE    = 5'h07;
    localparam logic [4:0] NUM_PROGRAMMABLE_TX_IRQ_TWO    = 5'h09;
    localparam logic [4:0] NUM_PROGRAMMABLE_RX_IRQ_THREE    = 5'h0B;
    localparam logic [4:0] NUM_WAKE_RTC = 5'h12;
    localparam logic [4:0] NUM_OS       = 5'h1A;

    // interrupts 16..23 take the high page pointer
    localparam logic [1:0] HIGH_PAGE_SEL = 2'h2;

    // serial-port mode field encodings
    localparam logic [1:0] SPMODE_CARD  = 2'h0;
    localparam logic [1:0] SPMODE_AUDIO = 2'h1;

    // reset values
    localparam logic [31:0] FLAGS_RST    = 32'h0000_0001;
    localparam logic [31:0] TRAP_RST     = 32'h0000_0000;
    localparam logic [31:0] NONMASK_BITS = 32'h0000_0001;

    // priority of each interrupt number; slots 12 and 13 are software only
    localparam logic [4:0] PRIO_TABLE [0:31] = '{
        5'h00, 5'h01, 5'h03, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0A,
        5'h0B, 5'h0D, 5'h0E, 5'h0F, 5'h1A, 5'h1A, 5'h15, 5'h16,
        5'h04, 5'h08, 5'h0C, 5'h10, 5'h13, 5'h14, 5'h17, 5'h18,
        5'h02, 5'h19, 5'h1A, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12
    };

    typedef enum logic [1:0] {
        DIVP_IDLE  = 2'b00,
        DIVP_OFFER = 2'b01
    } divp_state_t;

endpackage

// File: verilog/divp_vector_ctrl.sv
// Purpose: latch interrupt events, pick the most urgent one and present its vector
// Assumes: peripheral sources and software ports run on clk; external pins are async
// Notes:   one vector is offered at a time and held until the core acknowledges it
//
// Notes on behaviour
// - the reset vector sits at offset zero with priority zero and is raised by any reset
// - the non-maskable request is held inactive so no hardware event takes its slot
// - software trap one may use the offset 0x8 slot of the non-maskable interrupt
// - each relative byte offset is eight times the interrupt number, 0x0 up to 0xF8
// - numbers 0-15 and 24-31 add their offset to the low page pointer
// - numbers 16-23 add their offset to the high page pointer
// - external user irq zero goes to 0x10 at priority 3 and irq one to 0x18 at priority 5
// - programmable transmit zero, audio port zero transmit or card zero, goes to 0x28 prio 7
// - programmable receive one, audio port zero receive or card zero sdio, goes to 0x38 prio 10
// - programmable transmit two, audio port one transmit or card one, goes to 0x48 prio 13
// - programmable receive three, audio port one receive or card one sdio, goes to 0x58 prio 15
// - the wake-up pin and the real-time clock share one interrupt at 0x90, priority 12
// - the os kernel interrupt goes to 0xD0 at priority 26, the least urgent level
// - each programmable irq follows the card port for mode 00 and the audio port for mode 01
// - writing a one to a pending flag bit clears that flag, unless an event sets it in the same cycle
`timescale 1ns/100ps

module divp_vector_ctrl (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // external pins, asynchronous
    input  wire logic        ext_user_irq_zero_pin,
    input  wire logic        ext_user_irq_one_pin,
    input  wire logic        wakeup_pin,
    // peripheral sources, on clk
    input  wire logic        timer_aggregate_irq,
    input  wire logic        uart_irq,
    input  wire logic        dma_aggregate_irq,
    input  wire logic        audio0_tx_irq,
    input  wire logic        audio0_rx_irq,
    input  wire logic        card0_irq,
    input  wire logic        card0_sdio_irq,
    input  wire logic        audio1_tx_irq,
    input  wire logic        audio1_rx_irq,
    input  wire logic        card1_irq,
    input  wire logic        card1_sdio_irq,
    input  wire logic        audio2_tx_irq,
    input  wire logic        audio2_rx_irq,
    input  wire logic        audio3_tx_irq,
    input  wire logic        audio3_rx_irq,
    input  wire logic        rtc_irq,
    input  wire logic        spi_irq,
    input  wire logic        usb_irq,
    input  wire logic        gpio_aggregate_irq,
    input  wire logic        emif_error_irq,
    input  wire logic        i2c_irq,
    input  wire logic        bus_fault_irq,
    input  wire logic        data_logging_irq,
    input  wire logic        os_kernel_irq,
    // configuration from software
    input  wire logic [1:0]  serial_port_zero_select,
    input  wire logic [1:0]  serial_port_one_select,
    input  wire logic [31:0] irq_enable_mask,
    input  wire logic [23:0] vector_base_low_page,
    input  wire logic [23:0] vector_base_high_page,
    // software flag clear, write one to clear
    input  wire logic        flag_clear_wr,
    input  wire logic [31:0] flag_clear_data,
    // software reset and traps
    input  wire logic        soft_reset,
    input  wire logic        trap_req,
    input  wire logic [4:0]  trap_num,
    // vector fetch side
    input  wire logic        vector_ack,
    output logic             vector_req,
    output logic [31:0]      vector_addr_q,
    output logic [4:0]       vector_num_q,
    output logic [4:0]       vector_prio_q,
    // status
    output logic [31:0]      irq_pending_flags
);

    // relative byte offset of a vector slot
    function automatic logic [7:0] vec_offset(input logic [4:0] num);
        vec_offset = {num, 3'b000};
    endfunction

    // absolute vector address from the page pointer chosen by number
    function automatic logic [31:0] vec_address(input logic [4:0]  num,
                                                input logic [23:0] low_page,
                                                input logic [23:0] high_page);
        logic [23:0] page;
        page = (num[4:3] == divp_pkg::HIGH_PAGE_SEL) ? high_page : low_page;
        vec_address = {page, 8'h00} + {24'h00_0000, vec_offset(num)};
    endfunction

    // source selected by a serial-port mode field
    function automatic logic mode_pick(input logic [1:0] mode,
                                       input logic       card_src,
                                       input logic       audio_src);
        mode_pick = (mode == divp_pkg::SPMODE_CARD)  ? card_src :
                    (mode == divp_pkg::SPMODE_AUDIO) ? audio_src : 1'b0;
    endfunction

    // most urgent request; strict compare gives the lower number on a tie
    function automatic logic [5:0] pick_best(input logic [31:0] req);
        logic       found;
        logic [4:0] best_n;
        logic [4:0] best_p;
        found  = 1'b0;
        best_n = 5'h00;
        best_p = 5'h1F;
        for (int i = 0; i < 32; i++) begin
            if (req[i] && (!found || divp_pkg::PRIO_TABLE[i] < best_p)) begin
                found  = 1'b1;
                best_n = 5'(i);
                best_p = divp_pkg::PRIO_TABLE[i];
            end
        end
        pick_best = {found, best_n};
    endfunction

    // synchronisers for the async pins
    logic [2:0]  pin_sync1_q;
    logic [2:0]  pin_sync2_q;
    logic [31:0] hw_prev_q;
    logic [31:0] flags_q;
    logic [31:0] flags_d;
    logic [31:0] trap_q;
    logic [31:0] trap_d;
    divp_pkg::divp_state_t state_q;
    divp_pkg::divp_state_t state_d;
    logic [31:0] vec_addr_d;
    logic [4:0]  vec_num_d;
    logic [4:0]  vec_prio_d;

    wire logic [31:0] hw_level;
    wire logic [31:0] hw_set;
    wire logic [31:0] reset_set;
    wire logic [31:0] sw_clear;
    wire logic [31:0] ack_clear;
    wire logic [31:0] trap_set;
    wire logic [31:0] candidates;
    wire logic [5:0]  best;
    wire logic        best_found;
    wire logic [4:0]  best_num;
    wire logic        take;
    wire logic        retire;

    // programmable irqs and the wake-up/clock merge, by source
    wire logic        programmable_tx_irq_zero;
    wire logic        programmable_rx_irq_one;
    wire logic        programmable_tx_irq_two;
    wire logic        programmable_rx_irq_three;
    wire logic        wake_or_clock_irq;
    wire logic [31:0] enabled_flags;
    wire logic [4:0]  best_prio;
    wire logic [31:0] best_addr;

    // modes 10 and 11 connect no source, so the slot stays quiet
    assign programmable_tx_irq_zero  = mode_pick(serial_port_zero_select, card0_irq,
                                                 audio0_tx_irq);
    assign programmable_rx_irq_one   = mode_pick(serial_port_zero_select, card0_sdio_irq,
                                                 audio0_rx_irq);
    assign programmable_tx_irq_two   = mode_pick(serial_port_one_select, card1_irq,
                                                 audio1_tx_irq);
    assign programmable_rx_irq_three = mode_pick(serial_port_one_select, card1_sdio_irq,
                                                 audio1_rx_irq);
    assign wake_or_clock_irq         = pin_sync2_q[2] | rtc_irq;

    // interrupt number to source mapping
    assign hw_level[0]  = 1'b0;
    assign hw_level[1]  = 1'b0;
    assign hw_level[2]  = pin_sync2_q[0];
    assign hw_level[3]  = pin_sync2_q[1];
    assign hw_level[4]  = timer_aggregate_irq;
    assign hw_level[5]  = programmable_tx_irq_zero;
    assign hw_level[6]  = uart_irq;
    assign hw_level[7]  = programmable_rx_irq_one;
    assign hw_level[8]  = dma_aggregate_irq;
    assign hw_level[9]  = programmable_tx_irq_two;
    // slots 10, 12, 13 and 27 up have no hardware source and are reached by traps only
    assign hw_level[10] = 1'b0;
    assign hw_level[11] = programmable_rx_irq_three;
    assign hw_level[12] = 1'b0;
    assign hw_level[13] = 1'b0;
    assign hw_level[14] = audio2_tx_irq;
    assign hw_level[15] = audio2_rx_irq;
    assign hw_level[16] = audio3_tx_irq;
    assign hw_level[17] = audio3_rx_irq;
    assign hw_level[18] = wake_or_clock_irq;
    assign hw_level[19] = spi_irq;
    assign hw_level[20] = usb_irq;
    assign hw_level[21] = gpio_aggregate_irq;
    assign hw_level[22] = emif_error_irq;
    assign hw_level[23] = i2c_irq;
    assign hw_level[24] = bus_fault_irq;
    assign hw_level[25] = data_logging_irq;
    assign hw_level[26] = os_kernel_irq;
    assign hw_level[31:27] = 5'h00;

    // sources are flagged on their rising edge so a held line raises one request
    assign hw_set    = hw_level & ~hw_prev_q;
    assign reset_set = soft_reset ? divp_pkg::FLAGS_RST : 32'h0000_0000;
    assign sw_clear  = flag_clear_wr ? flag_clear_data : 32'h0000_0000;
    assign trap_set  = trap_req ? (32'h0000_0001 << trap_num) : 32'h0000_0000;
    // the ack retires the offered number in both the flag set and the trap set
    assign retire    = (state_q == divp_pkg::DIVP_OFFER) && vector_ack;
    assign ack_clear = retire ? (32'h0000_0001 << vector_num_q) : 32'h0000_0000;

    // set wins over clear so an event in the clearing cycle is kept
    assign flags_d = (flags_q & ~(sw_clear | ack_clear)) | hw_set | reset_set;
    assign trap_d  = (trap_q & ~ack_clear) | trap_set;

    // traps and the reset slot ignore the enable mask
    // bit 0 is never masked: the reset slot must always reach the core
    assign enabled_flags = flags_q & (irq_enable_mask | divp_pkg::NONMASK_BITS);
    assign candidates = enabled_flags | trap_q;
    assign best       = pick_best(candidates);
    assign best_found = best[5];
    assign best_num   = best[4:0];
    assign take       = (state_q == divp_pkg::DIVP_IDLE) && best_found;

    // a vector stays offered until acknowledged; flags settle before the next pick
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            divp_pkg::DIVP_IDLE: begin
                if (take) begin
                    state_d = divp_pkg::DIVP_OFFER;
                end
            end
            divp_pkg::DIVP_OFFER: begin
                if (vector_ack) begin
                    state_d = divp_pkg::DIVP_IDLE;
                end
            end
        endcase
    end

    // the offer is latched at take time, so later pointer writes do not move it
    assign best_prio  = divp_pkg::PRIO_TABLE[best_num];
    assign best_addr  = vec_address(best_num, vector_base_low_page,
                                    vector_base_high_page);
    assign vec_num_d  = take ? best_num : vector_num_q;
    assign vec_prio_d = take ? best_prio : vector_prio_q;
    assign vec_addr_d = take ? best_addr : vector_addr_q;

    // only the second stage is read; the first may still be settling
    always_ff @(posedge clk) begin
        pin_sync1_q <= {wakeup_pin, ext_user_irq_one_pin, ext_user_irq_zero_pin};
        pin_sync2_q <= pin_sync1_q;
    end

    // edge detectors start low, so a source already high at release flags at once
    always_ff @(posedge clk) begin
        if (!resetn) begin
            hw_prev_q <= 32'h0000_0000;
        end else begin
            hw_prev_q <= hw_level;
        end
    end

    // reset raises the reset slot so the core always fetches vector zero first
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flags_q <= divp_pkg::FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            trap_q <= divp_pkg::TRAP_RST;
        end else begin
            trap_q <= trap_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= divp_pkg::DIVP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            vector_addr_q <= 32'h0000_0000;
            vector_num_q  <= 5'h00;
            vector_prio_q <= 5'h00;
        end else begin
            vector_addr_q <= vec_addr_d;
            vector_num_q  <= vec_num_d;
            vector_prio_q <= vec_prio_d;
        end
    end

    assign vector_req        = (state_q == divp_pkg::DIVP_OFFER);
    assign irq_pending_flags = flags_q;

endmodule // divp_vector_ctrl
